//--- logic/dfs_params.svh
// Constants for the driver fault status and configuration register group.
// Assumes inclusion by bare name from the package and the main module.
`ifndef DFS_PARAMS_SVH
`define DFS_PARAMS_SVH

// Register addresses (6-bit register index of the serial frame)
`define DFS_ADDR_ULD        6'h11
`define DFS_ADDR_SUPPLY     6'h12
`define DFS_ADDR_CONFIG     6'h3F

// Field positions
`define DFS_ULD_MSB         9
`define DFS_ULD_LSB         6
`define DFS_SUP_LOW_BIT     3
`define DFS_SUP_HIGH_BIT    2
`define DFS_CFG_TW_MASK     3
`define DFS_CFG_ULD_MASK    1
`define DFS_CFG_SWAP        0

// Reset value and config write mask
`define DFS_REG_RESET       16'h0000
`define DFS_CFG_WMASK       16'h000B

// Underload filter time in ns, and its cycle count at 125 MHz (round up)
`define DFS_CLK_PERIOD_NS   8
`define DFS_ULD_FILT_NS     200
`define DFS_ULD_FILT_CYC    ((`DFS_ULD_FILT_NS + `DFS_CLK_PERIOD_NS - 1) / `DFS_CLK_PERIOD_NS)
`define DFS_FILT_W          8

// Serial frame: 1 write bit, 6 address bits, 16 data bits, 1 spare
`define DFS_FRAME_BITS      24
`define DFS_CNT_W           5
`define DFS_ADDR_W          6
`define DFS_DATA_W          16
`define DFS_STAGES          4

`endif

//--- logic/dfs_pkg.sv
// Types shared by the fault status register group.
// Assumes dfs_params.svh is on the include path.
`default_nettype none
`include "dfs_params.svh"
package dfs_pkg;
    // One stage's measurement inputs
    typedef struct packed {
        logic on;
        logic undercurrent;
    } dfs_stage_s;

    // Serial receiver states
    typedef enum logic [1:0] {
        DFS_IDLE  = 2'b00,
        DFS_SHIFT = 2'b01,
        DFS_DONE  = 2'b10
    } dfs_link_e;

    typedef logic [`DFS_DATA_W-1:0] dfs_word_t;
endpackage
`default_nettype wire

//--- logic/dfs_uld_filter.sv
// One underload filter: counts cycles of low current while the stage is on.
// Assumes inputs already synchronised to i_mclk.
`default_nettype none
`include "dfs_params.svh"
module dfs_uld_filter
(
    input  wire logic               i_mclk,
    input  wire logic               i_rst,
    input  wire logic               i_ce,
    input  wire dfs_pkg::dfs_stage_s i_stage,
    output logic                    o_hit
);
    logic [`DFS_FILT_W-1:0] cnt_ff;
    logic [`DFS_FILT_W-1:0] nxt_cnt;
    logic                   hit_ff;
    logic                   nxt_hit;

    // Count only in on-mode; any good sample restarts the filter
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_hit = 1'b0;
        if (!(i_stage.on && i_stage.undercurrent))
            nxt_cnt = '0;
        else if (cnt_ff < `DFS_FILT_W'(`DFS_ULD_FILT_CYC))
            nxt_cnt = cnt_ff + 1'b1;
        if (i_stage.on && i_stage.undercurrent &&
            cnt_ff + 1'b1 >= `DFS_FILT_W'(`DFS_ULD_FILT_CYC))
            nxt_hit = 1'b1;
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_ff <= '0;
            hit_ff <= 1'b0;
        end
        else if (i_ce)
        begin
            cnt_ff <= nxt_cnt;
            hit_ff <= nxt_hit;
        end
    end

    assign o_hit = hit_ff;
endmodule
`default_nettype wire

//--- logic/dfs_regs.sv
// Fault status and configuration registers of the half-bridge driver.
// Assumes a host on a serial link (mode 0, MSB first) and analog
// comparators whose outputs arrive asynchronously.
//
// How it works
// - Four per-stage underload flags sit in bits 9..6 at 0x11.
// - Underload counts only while on; filter time must elapse first.
// - Any new stage underload also sets the global underload summary.
// - Config bit 1 set keeps the underload summary low.
// - Undervoltage turns all stages off and sets bit 3 at 0x12.
// - Overvoltage turns all stages off and sets bit 2 at 0x12.
// - Latch select low: stages return once supply is valid again.
// - Latch select high: stages stay off until host clears the flag.
// - Config bit 3 at 0x3F suppresses the thermal warning summary.
// - Config bit 0 maps bridge b onto modulation input a.
// - Modulation-selected bridge is on while its input pin is high and stages are enabled.
`default_nettype none
`include "dfs_params.svh"
module dfs_regs
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_rst,
    input  wire logic                   i_ce,
    input  wire logic                   i_spi_sclk,
    input  wire logic                   i_spi_cs_n,
    input  wire logic                   i_spi_mosi,
    output logic                        o_spi_miso,
    input  wire logic [`DFS_STAGES-1:0] i_stage_on,
    input  wire logic [`DFS_STAGES-1:0] i_undercurrent,
    input  wire logic                   i_supply_low,
    input  wire logic                   i_supply_high,
    input  wire logic                   i_thermal_warning,
    input  wire logic                   i_supply_fault_latch_select,
    input  wire logic                   i_modulation_input_a,
    input  wire logic                   i_modulation_input_b,
    input  wire logic                   i_half_bridge_a_pwm_sel,
    input  wire logic                   i_half_bridge_b_pwm_sel,
    output logic                        o_stages_enable,
    output logic                        o_half_bridge_a,
    output logic                        o_half_bridge_b,
    output logic                        o_underload_summary,
    output logic                        o_thermal_warning_summary
);
    // ******************************************************************
    // Input synchronisers
    // ******************************************************************
    localparam int SYW = 7 + 2 * `DFS_STAGES;
    logic [SYW-1:0] sy1_ff;
    logic [SYW-1:0] sy2_ff;
    logic [SYW-1:0] nxt_sy1;
    logic [1:0]     warm_ff;
    logic [1:0]     nxt_warm;

    // Asynchronous pins but i_thermal_warning pass two flops; nothing reads sy1_ff but sy2_ff
    always_comb
    begin
        nxt_sy1 = {i_spi_sclk, i_spi_cs_n, i_spi_mosi, i_supply_low,
                   i_supply_high, i_modulation_input_a,
                   i_modulation_input_b, i_stage_on, i_undercurrent};
        // Synced levels are trusted only once both stages hold pin values
        nxt_warm = {warm_ff[0], 1'b1};
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sy1_ff <= '0;
            warm_ff <= '0;
            sy2_ff <= '0;
        end
        else if (i_ce)
        begin
            sy1_ff <= nxt_sy1;
            warm_ff <= nxt_warm;
            sy2_ff <= sy1_ff;
        end
    end

    logic                   s_sclk;
    logic                   s_cs_n;
    logic                   s_mosi;
    logic                   s_uv;
    logic                   s_ov;
    logic                   s_pwm_a;
    logic                   s_pwm_b;
    logic [`DFS_STAGES-1:0] s_on;
    logic [`DFS_STAGES-1:0] s_uc;
    assign {s_sclk, s_cs_n, s_mosi, s_uv, s_ov, s_pwm_a, s_pwm_b,
            s_on, s_uc} = sy2_ff;

    // ******************************************************************
    // Underload filters, one per stage
    // ******************************************************************
    logic [`DFS_STAGES-1:0] uld_hit;
    genvar gi;
    generate
        for (gi = 0; gi < `DFS_STAGES; gi++)
        begin : g_uld
            dfs_uld_filter u_filt
            (
                .i_mclk  (i_mclk),
                .i_rst   (i_rst),
                .i_ce    (i_ce),
                .i_stage ({s_on[gi], s_uc[gi]}),
                .o_hit   (uld_hit[gi])
            );
        end
    endgenerate

    // ******************************************************************
    // Serial link receiver
    // ******************************************************************
    dfs_pkg::dfs_link_e         st_ff;
    dfs_pkg::dfs_link_e         nxt_st;
    logic                       sclk_d_ff;
    logic [`DFS_CNT_W-1:0]      bit_ff;
    logic [`DFS_CNT_W-1:0]      nxt_bit;
    logic [`DFS_FRAME_BITS-1:0] rx_ff;
    logic [`DFS_FRAME_BITS-1:0] nxt_rx;
    logic [`DFS_DATA_W-1:0]     tx_ff;
    logic [`DFS_DATA_W-1:0]     nxt_tx;
    logic                       miso_ff;
    logic                       nxt_miso;
    logic                       rd_pulse;
    logic                       wr_pulse;
    logic [`DFS_ADDR_W-1:0]     addr;
    logic                       sclk_rise;
    logic                       sclk_fall;
    logic [`DFS_ADDR_W-1:0]     hdr_addr;
    logic                       hdr_wr;

    // At the seventh rise the last address bit is still on the line
    assign hdr_wr   = rx_ff[`DFS_ADDR_W-1];
    assign hdr_addr = {rx_ff[`DFS_ADDR_W-2:0], s_mosi};

    assign sclk_rise = s_sclk && !sclk_d_ff;
    assign sclk_fall = !s_sclk && sclk_d_ff;
    assign addr      = rx_ff[`DFS_FRAME_BITS-2 -: `DFS_ADDR_W];

    // ******************************************************************
    // Register storage
    // ******************************************************************
    logic [`DFS_STAGES-1:0] uld_ff;
    logic [`DFS_STAGES-1:0] nxt_uld;
    logic                   uv_ff;
    logic                   nxt_uv;
    logic                   ov_ff;
    logic                   nxt_ov;
    dfs_pkg::dfs_word_t     cfg_ff;
    dfs_pkg::dfs_word_t     nxt_cfg;
    logic                   summ_ff;
    logic                   nxt_summ;
    logic                   en_ff;
    logic                   nxt_en;
    logic                   hba_ff;
    logic                   nxt_hba;
    logic                   hbb_ff;
    logic                   nxt_hbb;
    logic                   tw_ff;
    logic                   nxt_tw;
    dfs_pkg::dfs_word_t     rd_word;

    // Read mux: unmapped addresses and unused bits answer zero
    always_comb
    begin
        rd_word = `DFS_REG_RESET;
        case (hdr_addr)
            `DFS_ADDR_ULD:
                rd_word[`DFS_ULD_MSB:`DFS_ULD_LSB] = uld_ff;
            `DFS_ADDR_SUPPLY:
            begin
                rd_word[`DFS_SUP_LOW_BIT]  = uv_ff;
                rd_word[`DFS_SUP_HIGH_BIT] = ov_ff;
            end
            `DFS_ADDR_CONFIG:
                rd_word = cfg_ff;
            default:
                rd_word = `DFS_REG_RESET;
        endcase
    end

    // Frame state: address arrives in first 7 bits, reply follows in-frame
    always_comb
    begin
        nxt_st   = st_ff;
        nxt_bit  = bit_ff;
        nxt_rx   = rx_ff;
        nxt_tx   = tx_ff;
        nxt_miso = miso_ff;
        rd_pulse = 1'b0;
        wr_pulse = 1'b0;
        case (st_ff)
            dfs_pkg::DFS_IDLE:
            begin
                nxt_bit  = '0;
                nxt_miso = 1'b0;
                if (!s_cs_n)
                    nxt_st = dfs_pkg::DFS_SHIFT;
            end
            dfs_pkg::DFS_SHIFT:
            begin
                if (s_cs_n)
                    nxt_st = dfs_pkg::DFS_IDLE; // Short frame dropped
                else if (sclk_rise)
                begin
                    nxt_rx  = {rx_ff[`DFS_FRAME_BITS-2:0], s_mosi};
                    nxt_bit = bit_ff + 1'b1;
                    if (bit_ff == `DFS_CNT_W'(`DFS_ADDR_W))
                    begin
                        // Address now complete: latch reply word
                        nxt_tx   = rd_word;
                        rd_pulse = !hdr_wr;
                    end
                    if (bit_ff == `DFS_CNT_W'(`DFS_FRAME_BITS - 1))
                        nxt_st = dfs_pkg::DFS_DONE;
                end
                else if (sclk_fall && bit_ff > `DFS_CNT_W'(`DFS_ADDR_W))
                begin
                    nxt_miso = tx_ff[`DFS_DATA_W-1];
                    nxt_tx   = {tx_ff[`DFS_DATA_W-2:0], 1'b0};
                end
            end
            dfs_pkg::DFS_DONE:
            begin
                // Write commits only on a complete frame at chip deselect
                if (s_cs_n)
                begin
                    wr_pulse = rx_ff[`DFS_FRAME_BITS-1];
                    nxt_st   = dfs_pkg::DFS_IDLE;
                end
            end
            default:
                nxt_st = dfs_pkg::DFS_IDLE;
        endcase
    end

    logic rd_uld;
    logic rd_sup;
    assign rd_uld = rd_pulse &&
        hdr_addr == `DFS_ADDR_ULD;
    assign rd_sup = rd_pulse &&
        hdr_addr == `DFS_ADDR_SUPPLY;

    // Flags: a new event in the read cycle wins over the clear
    always_comb
    begin
        nxt_uld  = (rd_uld ? '0 : uld_ff) | uld_hit;
        nxt_uv   = (rd_sup ? 1'b0 : uv_ff) | s_uv;
        nxt_ov   = (rd_sup ? 1'b0 : ov_ff) | s_ov;
        nxt_cfg  = cfg_ff;
        if (wr_pulse && addr == `DFS_ADDR_CONFIG)
            nxt_cfg = rx_ff[`DFS_DATA_W:1] & `DFS_CFG_WMASK;
        // Summary follows any set stage flag unless masked
        nxt_summ = (|nxt_uld) && !cfg_ff[`DFS_CFG_ULD_MASK];
        nxt_tw   = i_thermal_warning && !cfg_ff[`DFS_CFG_TW_MASK];
        // Stages off immediately on a live fault; latched mode waits on flags
        // Warm-up keeps stages off while synchronisers hold reset zeros
        if (!warm_ff[1] || s_uv || s_ov)
            nxt_en = 1'b0;
        else if (i_supply_fault_latch_select)
            nxt_en = !(uv_ff || ov_ff);
        else
            nxt_en = 1'b1;
        // Modulation path; bridge b may borrow input a
        nxt_hba = i_half_bridge_a_pwm_sel && s_pwm_a && nxt_en;
        nxt_hbb = i_half_bridge_b_pwm_sel && nxt_en &&
                  (cfg_ff[`DFS_CFG_SWAP] ? s_pwm_a : s_pwm_b);
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_ff     <= dfs_pkg::DFS_IDLE;
            sclk_d_ff <= 1'b0;
            bit_ff    <= '0;
            rx_ff     <= '0;
            tx_ff     <= `DFS_REG_RESET;
            miso_ff   <= 1'b0;
            uld_ff    <= '0;
            uv_ff     <= 1'b0;
            ov_ff     <= 1'b0;
            cfg_ff    <= `DFS_REG_RESET;
            summ_ff   <= 1'b0;
            tw_ff     <= 1'b0;
            en_ff     <= 1'b0;
            hba_ff    <= 1'b0;
            hbb_ff    <= 1'b0;
        end
        else if (i_ce)
        begin
            st_ff     <= nxt_st;
            sclk_d_ff <= s_sclk;
            bit_ff    <= nxt_bit;
            rx_ff     <= nxt_rx;
            tx_ff     <= nxt_tx;
            miso_ff   <= nxt_miso;
            uld_ff    <= nxt_uld;
            uv_ff     <= nxt_uv;
            ov_ff     <= nxt_ov;
            cfg_ff    <= nxt_cfg;
            summ_ff   <= nxt_summ;
            tw_ff     <= nxt_tw;
            en_ff     <= nxt_en;
            hba_ff    <= nxt_hba;
            hbb_ff    <= nxt_hbb;
        end
    end

    // ******************************************************************
    // Outputs, all registered
    // ******************************************************************
    assign o_spi_miso                = miso_ff;
    assign o_stages_enable           = en_ff;
    assign o_half_bridge_a           = hba_ff;
    assign o_half_bridge_b           = hbb_ff;
    assign o_underload_summary       = summ_ff;
    assign o_thermal_warning_summary = tw_ff;
endmodule
`default_nettype wire

//--- verification/dfs_regs_checker.sv
// Port assertions for the fault status and configuration registers.
// Assumes a bind onto dfs_regs from the bench top.
`default_nettype none
module dfs_regs_checker
(
    input wire logic       i_mclk,
    input wire logic       i_rst,
    input wire logic       i_spi_cs_n,
    input wire logic [3:0] i_stage_on,
    input wire logic [3:0] i_undercurrent,
    input wire logic       i_supply_low,
    input wire logic       i_supply_high,
    input wire logic       i_thermal_warning,
    input wire logic       i_supply_fault_latch_select,
    input wire logic       i_modulation_input_a,
    input wire logic       i_half_bridge_a_pwm_sel,
    input wire logic       o_stages_enable,
    input wire logic       o_half_bridge_a,
    input wire logic       o_underload_summary,
    input wire logic       o_thermal_warning_summary
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking dc @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    // Latched trip followed by a silent link: no read, so no restart
    sequence s_latched_trip;
        $fell(o_stages_enable) && i_supply_fault_latch_select;
    endsequence
    sequence s_quiet_link;
        (i_spi_cs_n && i_supply_fault_latch_select) [*8];
    endsequence

    supply_low_off_a: assert property (
        i_supply_low [*5] |-> !o_stages_enable) else $error("on in low supply");
    supply_high_off_a: assert property (
        i_supply_high [*5] |-> !o_stages_enable) else $error("on in high supply");
    auto_restart_a: assert property (
        (!i_supply_low && !i_supply_high && !i_supply_fault_latch_select) [*8]
        |-> o_stages_enable) else $error("no restart");
    latch_hold_a: assert property (
        s_latched_trip ##1 s_quiet_link |-> !o_stages_enable)
        else $error("restart without flag read");
    bridge_drive_a: assert property (
        (i_half_bridge_a_pwm_sel && i_modulation_input_a && o_stages_enable)
        [*5] |-> o_half_bridge_a) else $error("bridge a not driven");
    bridge_gate_a: assert property (
        o_half_bridge_a |-> o_stages_enable && $past(i_half_bridge_a_pwm_sel))
        else $error("bridge a driven while not allowed");
    warning_source_a: assert property (
        o_thermal_warning_summary |-> $past(i_thermal_warning))
        else $error("warning summary without warning");
    underload_cause_a: assert property (
        $rose(o_underload_summary) |-> $past(|(i_stage_on & i_undercurrent), 4))
        else $error("underload summary without cause");
endmodule
`default_nettype wire

//--- verification/dfs_host.sv
// Host model on the serial link: mode 0 frames, MSB first.
// Assumes xfer is called just after a rising edge of i_mclk.
`default_nettype none
module dfs_host
(
    input  wire logic i_mclk,
    input  wire logic i_miso,
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_mosi
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Frame driver
    // ****************************************
    // Link clock stands low between frames
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // Half period of 4 cycles gives the 64 ns link clock
    task automatic xfer(input logic wr, input logic [5:0] adr,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [23:0] f;
        f = {wr, adr, wd, 1'b0};
        rd = 16'h0000;
        o_cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            o_mosi <= f[i];
            repeat (4) @(posedge i_mclk);
            o_sclk <= 1'b1;
            if (i >= 1 && i <= 16)
                rd[i-1] = i_miso;
            repeat (4) @(posedge i_mclk);
            o_sclk <= 1'b0;
        end
        // Released line shows the inverse so a stale bit cannot pass
        o_mosi <= ~f[0];
        repeat (4) @(posedge i_mclk);
        o_cs_n <= 1'b1;
        repeat (8) @(posedge i_mclk);
    endtask
endmodule
`default_nettype wire

//--- verification/tb_dfs_regs.sv
// Self-checking bench for the fault status and configuration registers.
// Assumes dfs_pkg, dfs_regs, dfs_host and the checker compiled first.
`default_nettype none
module tb_dfs_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Signals, instances and tasks
    // ****************************************
    logic i_mclk, i_rst, i_ce, i_spi_sclk, i_spi_cs_n, i_spi_mosi;
    logic o_spi_miso, i_supply_low, i_supply_high, i_thermal_warning;
    logic [3:0] i_stage_on, i_undercurrent;
    logic i_supply_fault_latch_select, i_half_bridge_a_pwm_sel;
    logic i_modulation_input_a, i_modulation_input_b;
    logic i_half_bridge_b_pwm_sel, o_stages_enable, o_half_bridge_a;
    logic o_half_bridge_b, o_underload_summary, o_thermal_warning_summary;
    dfs_pkg::dfs_word_t rd;
    int err_count = 0;
    int checked = 0;

    dfs_regs dut
    (
        .i_mclk, .i_rst, .i_ce, .i_spi_sclk, .i_spi_cs_n, .i_spi_mosi,
        .o_spi_miso, .i_stage_on, .i_undercurrent, .i_supply_low,
        .i_supply_high, .i_thermal_warning, .i_supply_fault_latch_select,
        .i_modulation_input_a, .i_modulation_input_b,
        .i_half_bridge_a_pwm_sel, .i_half_bridge_b_pwm_sel,
        .o_stages_enable, .o_half_bridge_a, .o_half_bridge_b,
        .o_underload_summary, .o_thermal_warning_summary
    );
    dfs_host host
    (
        .i_mclk, .i_miso(o_spi_miso), .o_sclk(i_spi_sclk),
        .o_cs_n(i_spi_cs_n), .o_mosi(i_spi_mosi)
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic chkhb(input logic [1:0] e);
        chk({14'h0000, o_half_bridge_a, o_half_bridge_b}, {14'h0000, e});
    endtask
    task automatic rdreg(input logic [5:0] a, input logic [15:0] e);
        host.xfer(1'b0, a, 16'h0000, rd);
        chk(rd, e);
    endtask
    task automatic results();
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // 8 ns system clock
    initial
    begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    // About 2900 cycles of frames; far beyond that means a hang
    initial
    begin
        cyc(20000);
        err_count++;
        results();
    end
    // ****************************************
    // Test sequence
    // ****************************************
    // Inputs change by non-blocking assignment on rising edges
    initial
    begin
        {i_rst, i_ce, i_modulation_input_a} = 3'h7;
        {i_half_bridge_a_pwm_sel, i_half_bridge_b_pwm_sel} = 2'h3;
        {i_supply_low, i_supply_high, i_thermal_warning} = 3'h0;
        {i_supply_fault_latch_select, i_modulation_input_b} = 2'h0;
        {i_stage_on, i_undercurrent} = 8'h00;
        cyc(2);
        i_rst <= 1'b0;
        cyc(6);
        chk1(o_stages_enable, 1'b1);
        rdreg(6'h11, 16'h0000);
        rdreg(6'h12, 16'h0000);
        rdreg(6'h3F, 16'h0000);
        host.xfer(1'b1, 6'h3F, 16'hFFFF, rd);
        rdreg(6'h3F, 16'h000B);
        rdreg(6'h20, 16'h0000);
        chkhb(2'h3);
        // Masks set: flag still latches, summaries stay quiet
        i_thermal_warning <= 1'b1;
        {i_stage_on, i_undercurrent} <= 8'h46;
        cyc(40);
        chk1(o_thermal_warning_summary, 1'b0);
        chk1(o_underload_summary, 1'b0);
        {i_stage_on, i_undercurrent} <= 8'h00;
        rdreg(6'h11, 16'h0100);
        rdreg(6'h11, 16'h0000);
        host.xfer(1'b1, 6'h3F, 16'h0000, rd);
        chk1(o_thermal_warning_summary, 1'b1);
        chkhb(2'h2);
        // Low clock enable freezes the bridges; then b follows its own pin
        i_ce <= 1'b0;
        {i_modulation_input_a, i_modulation_input_b} <= 2'h1;
        cyc(10);
        chkhb(2'h2);
        i_ce <= 1'b1;
        cyc(6);
        chkhb(2'h1);
        {i_modulation_input_a, i_modulation_input_b} <= 2'h2;
        cyc(6);
        chkhb(2'h2);
        // Short pulse on one stage, then a long one on another
        {i_stage_on, i_undercurrent} <= 8'h88;
        cyc(10);
        {i_stage_on, i_undercurrent} <= 8'h11;
        cyc(40);
        chk1(o_underload_summary, 1'b1);
        {i_stage_on, i_undercurrent} <= 8'h00;
        rdreg(6'h11, 16'h0040);
        // Both supply faults, with and without the restart latch
        for (int k = 0; k < 4; k++)
        begin
            i_supply_fault_latch_select <= k[1];
            {i_supply_low, i_supply_high} <= {~k[0], k[0]};
            cyc(6);
            chk1(o_stages_enable, 1'b0);
            {i_supply_low, i_supply_high} <= 2'h0;
            cyc(12);
            chk1(o_stages_enable, ~k[1]);
            rdreg(6'h12, k[0] ? 16'h0004 : 16'h0008);
            cyc(6);
            chk1(o_stages_enable, 1'b1);
        end
        results();
    end
endmodule

bind dfs_regs dfs_regs_checker u_chk
(
    .i_mclk, .i_rst, .i_spi_cs_n, .i_stage_on, .i_undercurrent,
    .i_supply_low, .i_supply_high, .i_thermal_warning,
    .i_supply_fault_latch_select, .i_modulation_input_a,
    .i_half_bridge_a_pwm_sel, .o_stages_enable, .o_half_bridge_a,
    .o_underload_summary, .o_thermal_warning_summary
);
`default_nettype wire
